// [design/pad_decoder.sv]
// Peripheral area decoder: fixed area and relocatable window select logic
`timescale 1ns/10ps
// Function
// [RULE_01] A 16 KB relocatable window, offsets 0000H to 3FFFH above the selected base, is decoded.
// [RULE_02] Window offsets 2000H to 2FFFH go to the CAN controller only.
// [RULE_03] The peripheral bus is active for a hit in the fixed area or in the window.
// [RULE_04] The window starts on a page whose nibble low bits are 00 and ends on one with 11.
// [RULE_05] The top 4 KB of the window aliases the fixed area, so writes there change it.
// [RULE_06] Software keeps out of the aliased top 4 KB and reaches the fixed area only at FFFF000H.
// [RULE_07] The window base comes from the software programmed base select register.
// [RULE_08] An address in both the fixed area and the window selects the fixed area only.
module pad_decoder (
  input wire logic clk,
  input wire logic rst_n,
  input wire pad_pkg::pad_req_t req,
  input wire logic [13:0] peripheral_window_base_select,
  input wire logic window_enable,
  output pad_pkg::pad_sel_t sel
);

  // ==========================================================================
  // Decode helpers

  // Window span runs from page bits 00 to 11 above the base, so it stays 16 KB aligned
  function automatic logic in_window(input logic [27:0] a, input logic [13:0] b);
    logic [27:0] lo;
    logic [27:0] hi;
    lo = {b, pad_pkg::START_NIB, pad_pkg::WIN_LO[11:0]};
    hi = {b, pad_pkg::END_NIB, pad_pkg::WIN_HI[11:0]};
    in_window = (a >= lo) && (a <= hi); // RULE_04
  endfunction : in_window

  // True when the address lies in the fixed 4 KB peripheral page
  function automatic logic in_fixed(input logic [27:0] a);
    in_fixed = (a[27:12] == pad_pkg::FIXED_PAGE);
  endfunction : in_fixed

  // Classify a window offset by target
  function automatic pad_pkg::pad_tgt_t win_target(input logic [13:0] o);
    if (o >= pad_pkg::CAN_LO && o <= pad_pkg::CAN_HI) begin
      win_target = pad_pkg::PAD_TGT_CAN;
    end else if (o >= pad_pkg::ALIAS_LO && o <= pad_pkg::ALIAS_HI) begin
      win_target = pad_pkg::PAD_TGT_FIXED;
    end else begin
      win_target = pad_pkg::PAD_TGT_PROG;
    end
  endfunction : win_target

  // ==========================================================================
  // Window base register

  logic [13:0] base;
  logic win_en;
  logic [13:0] next_base;
  logic next_win_en;

  // Base follows the select register; a change takes effect one cycle later
  always_comb begin
    next_base = peripheral_window_base_select; // RULE_07
    next_win_en = window_enable;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      base <= pad_pkg::BASE_RST;
      win_en <= pad_pkg::WIN_EN_RST;
    end else begin
      base <= next_base;
      win_en <= next_win_en;
    end
  end

  // ==========================================================================
  // Address decode

  // Decode stage signals; the span limits live in in_window
  logic hit_fixed;
  logic hit_win;
  logic [13:0] win_ofs;
  pad_pkg::pad_tgt_t tgt;
  pad_pkg::pad_sel_t next_sel;

  // Fixed area wins on overlap, so each access reaches at most one target
  always_comb begin
    hit_fixed = req.valid && in_fixed(req.addr);
    hit_win = req.valid && win_en && in_window(req.addr, base); // RULE_01
    win_ofs = req.addr[13:0];
    tgt = pad_pkg::PAD_TGT_NONE;
    if (hit_fixed) begin
      tgt = pad_pkg::PAD_TGT_FIXED; // RULE_08
    end else if (hit_win) begin
      tgt = win_target(win_ofs); // RULE_02
    end
    next_sel = '0;
    next_sel.bus_active = hit_fixed || hit_win; // RULE_03
    next_sel.sel_fixed = (tgt == pad_pkg::PAD_TGT_FIXED); // RULE_05
    next_sel.sel_can = (tgt == pad_pkg::PAD_TGT_CAN); // RULE_02
    next_sel.sel_prog = (tgt == pad_pkg::PAD_TGT_PROG);
    // Aliased hits still reach the fixed area; flag kept for debug only
    next_sel.alias_hit = hit_win && !hit_fixed && (tgt == pad_pkg::PAD_TGT_FIXED); // RULE_06
    next_sel.write = req.valid && req.write;
    if (tgt == pad_pkg::PAD_TGT_FIXED) begin
      next_sel.offset = {2'h0, req.addr[11:0]}; // RULE_05
    end else if (tgt != pad_pkg::PAD_TGT_NONE) begin
      next_sel.offset = win_ofs;
    end
  end

  // One register stage so every output comes straight from a flip-flop
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel <= '0;
    end else begin
      sel <= next_sel;
    end
  end

  // ==========================================================================
  // Assertions

  pad_pkg::pad_req_t req_q;
  logic [13:0] base_q;
  logic win_en_q;

  // Copy of the inputs seen by the decode stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_q <= '0;
      base_q <= pad_pkg::BASE_RST;
      win_en_q <= pad_pkg::WIN_EN_RST;
    end else begin
      req_q <= req;
      base_q <= base;
      win_en_q <= win_en;
    end
  end

  // One clock domain, so the checks share one clocking and one reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Routing checks compare each answer with the request one edge earlier
  fixed_hit_sel_a: assert property ( // RULE_08
    req.valid && in_fixed(req.addr) |=> sel.sel_fixed && !sel.sel_can && !sel.sel_prog)
    else $error("fixed area access not routed to fixed target");

  can_range_a: assert property ( // RULE_02
    sel.sel_can |-> req_q.valid && win_en_q && !in_fixed(req_q.addr)
      && in_window(req_q.addr, base_q)
      && req_q.addr[13:0] >= 14'h2000 && req_q.addr[13:0] <= 14'h2fff)
    else $error("can select outside its sub-range");

  bus_active_a: assert property ( // RULE_03
    sel.bus_active == (sel.sel_fixed || sel.sel_can || sel.sel_prog))
    else $error("bus activity does not match target select");

  one_target_a: assert property ( // RULE_08
    $onehot0({sel.sel_fixed, sel.sel_can, sel.sel_prog}))
    else $error("more than one target selected");

  win_span_a: assert property ( // RULE_01
    sel.sel_prog |-> req_q.addr[27:14] == base_q
      && req_q.addr[13:0] <= 14'h1fff && win_en_q)
    else $error("window select outside the 16 KB span");

  alias_route_a: assert property ( // RULE_05
    sel.alias_hit |-> sel.sel_fixed && sel.offset == {2'h0, req_q.addr[11:0]}
      && req_q.addr[13:12] == 2'h3)
    else $error("aliased access not routed to fixed area");

  base_follow_a: assert property ( // RULE_07
    window_enable ##1 req.valid && !in_fixed(req.addr)
      && req.addr[27:14] == $past(peripheral_window_base_select) |=> sel.bus_active)
    else $error("window base not taken from base select");

  win_miss_a: assert property ( // RULE_03
    req.valid && !in_fixed(req.addr) && !(win_en && in_window(req.addr, base))
      |=> !sel.bus_active)
    else $error("bus active on an unmapped address");

  span_nibs_a: assert property ( // RULE_04
    sel.alias_hit |-> win_en_q && req_q.addr[27:14] == base_q)
    else $error("aliased access outside the window span");

  win_offset_a: assert property ( // RULE_01
    sel.sel_prog || sel.sel_can |-> sel.offset == req_q.addr[13:0])
    else $error("window offset not passed through");

  fixed_offset_a: assert property ( // RULE_06
    sel.sel_fixed && !sel.alias_hit |-> in_fixed(req_q.addr)
      && sel.offset == {2'h0, req_q.addr[11:0]})
    else $error("fixed target reached outside the fixed page");

  miss_offset_a: assert property ( // RULE_03
    !sel.bus_active |-> sel.offset == 14'h0000)
    else $error("offset not cleared on a miss");

  win_off_a: assert property ( // RULE_07
    !win_en_q |-> !sel.sel_can && !sel.sel_prog && !sel.alias_hit)
    else $error("window target selected while the window is off");

  // Idle cycles show garbage on the address, so no select may follow them
  idle_quiet_a: assert property ( // RULE_03
    !req_q.valid |-> !sel.bus_active && !sel.write)
    else $error("select raised without a request");

  write_copy_a: assert property ( // RULE_05
    sel.write == (req_q.valid && req_q.write))
    else $error("write flag does not follow the request");

  // Reset has to clear state even mid-access, so this check ignores the default disable
  reset_clear_a: assert property (disable iff (1'b0) // RULE_03
    !rst_n |=> sel == '0 && win_en == pad_pkg::WIN_EN_RST && base == pad_pkg::BASE_RST)
    else $error("outputs or window state not cleared by reset");

  // ==========================================================================
  // Cover points

  can_hit_c: cover property (sel.sel_can && sel.write);
  prog_hit_c: cover property (sel.sel_prog);
  alias_hit_c: cover property (sel.alias_hit && sel.sel_fixed && sel.write);
  overlap_c: cover property (req.valid && in_fixed(req.addr) && win_en
    && in_window(req.addr, base));

endmodule : pad_decoder

// [dv/pad_core_model.sv]
// Processor core model that issues accesses to the decoder
`timescale 1ns/10ps
module pad_core_model (
  input wire logic clk,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [27:0] cmd_addr,
  output pad_pkg::pad_req_t req
);
  logic [27:0] last_addr = 28'h0;
  // ==========================================================================
  // Idle cycles show the inverted last access, so a decoder ignoring valid shows up
  always_comb begin
    req.valid = cmd_valid;
    req.write = cmd_valid ? cmd_write : ~cmd_write;
    req.addr = cmd_valid ? cmd_addr : ~last_addr;
  end
  // Fixed area only at its own page; alias page only when a scenario aims there
  always_ff @(posedge clk) begin
    if (cmd_valid) begin
      last_addr <= cmd_addr;
    end
  end
endmodule : pad_core_model

// [dv/peripheral_area_decoder_tb.sv]
// Self-checking testbench for the peripheral area decoder
`timescale 1ns/10ps
module peripheral_area_decoder_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [27:0] cmd_addr = 28'h0;
  logic [13:0] base = 14'h0;
  logic win_en = 1'b0;
  pad_pkg::pad_req_t req;
  pad_pkg::pad_sel_t sel;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  // ==========================================================================
  // Clock, core model and decoder
  initial begin
    forever #20 clk = ~clk;
  end
  pad_core_model core (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .req(req));
  pad_decoder uut (.clk(clk), .rst_n(rst_n), .req(req),
    .peripheral_window_base_select(base), .window_enable(win_en), .sel(sel));
  // ==========================================================================
  // Helpers; fcp is fixed, can, prog
  function automatic pad_pkg::pad_sel_t mk(logic [2:0] fcp, logic al, logic wr,
      logic [13:0] ofs);
    mk = {|fcp, fcp, al, wr, ofs};
  endfunction : mk
  // Valid stays up between calls, so calls in a row are back to back
  task automatic access(logic [27:0] a, logic wr, pad_pkg::pad_sel_t exp);
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_addr = a;
    @(negedge clk);
    compares++;
    if (sel !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED sel at %h expected %h seen %h", a, exp, sel);
    end
  endtask : access
  // Window settings need one edge before a request may rely on them
  task automatic set_win(logic [13:0] b, logic en);
    base = b;
    win_en = en;
    cmd_valid = 1'b0;
    @(negedge clk);
  endtask : set_win
  // ==========================================================================
  // Scenarios
  task automatic t_fixed();
    access(28'hffff010, 1'b0, mk(3'b100, 1'b0, 1'b0, 14'h0010));
    access(28'hfffffff, 1'b1, mk(3'b100, 1'b0, 1'b1, 14'h0fff));
    set_win(14'h0100, 1'b0);
    access(28'h0402010, 1'b0, '0);
  endtask : t_fixed
  task automatic t_window();
    set_win(14'h0100, 1'b1);
    access(28'h0400000, 1'b0, mk(3'b001, 1'b0, 1'b0, 14'h0000));
    access(28'h0401fff, 1'b1, mk(3'b001, 1'b0, 1'b1, 14'h1fff));
    access(28'h0402000, 1'b1, mk(3'b010, 1'b0, 1'b1, 14'h2000));
    access(28'h0402fff, 1'b0, mk(3'b010, 1'b0, 1'b0, 14'h2fff));
    access(28'h0403004, 1'b1, mk(3'b100, 1'b1, 1'b1, 14'h0004));
    access(28'h0404000, 1'b0, '0);
    access(28'h03fffff, 1'b0, '0);
  endtask : t_window
  task automatic t_rebase();
    set_win(14'h0101, 1'b1);
    access(28'h0402000, 1'b0, '0);
    access(28'h0406000, 1'b0, mk(3'b010, 1'b0, 1'b0, 14'h2000));
    set_win(14'h3fff, 1'b1);
    access(28'hffff010, 1'b0, mk(3'b100, 1'b0, 1'b0, 14'h0010));
    access(28'hfffe123, 1'b0, mk(3'b010, 1'b0, 1'b0, 14'h2123));
    set_win(14'h3fff, 1'b0);
    access(28'hfffc000, 1'b0, '0);
  endtask : t_rebase
  // Mid-run reset clears the outputs and the window enable for one edge
  task automatic t_reset();
    set_win(14'h0100, 1'b1);
    rst_n = 1'b0;
    access(28'hffff010, 1'b0, '0);
    rst_n = 1'b1;
    access(28'h0400000, 1'b0, '0);
    access(28'h0400000, 1'b0, mk(3'b001, 1'b0, 1'b0, 14'h0000));
  endtask : t_reset
  // ==========================================================================
  // Verdict and hang guard
  task automatic close_out();
    $display("Mismatches %0d of %0d compares", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out
  always @(posedge clk) begin
    cycles++;
    if (cycles == 400) begin
      n_mismatch++;
      close_out();
    end
  end
  // Reset for three cycles, then the scenarios
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_fixed();
    t_window();
    t_rebase();
    t_reset();
    close_out();
  end
endmodule : peripheral_area_decoder_tb

// [pkg/pad_pkg.sv]
// Package with address map constants and carrier types for the peripheral area decoder
package pad_pkg;

  // ==========================================================================
  // Address widths
  localparam int ADDR_W = 28;
  localparam int BASE_W = 14;
  localparam int WOFS_W = 14;
  localparam int FOFS_W = 12;

  // ==========================================================================
  // Fixed peripheral area, top 4 KB of the address space
  localparam logic [15:0] FIXED_PAGE = 16'hffff;
  localparam logic [27:0] FIXED_LO = 28'hffff000;
  localparam logic [27:0] FIXED_HI = 28'hfffffff;

  // ==========================================================================
  // Offsets inside the relocatable 16 KB window
  localparam logic [13:0] WIN_LO = 14'h0000;
  localparam logic [13:0] WIN_HI = 14'h3fff;
  localparam logic [13:0] CAN_LO = 14'h2000;
  localparam logic [13:0] CAN_HI = 14'h2fff;
  localparam logic [13:0] ALIAS_LO = 14'h3000;
  localparam logic [13:0] ALIAS_HI = 14'h3fff;
  // Nibble code of the window start and end pages
  localparam logic [1:0] START_NIB = 2'h0;
  localparam logic [1:0] END_NIB = 2'h3;

  // ==========================================================================
  // Reset values
  localparam logic [13:0] BASE_RST = 14'h0000;
  localparam logic WIN_EN_RST = 1'b0;

  // Access request from the processor core
  typedef struct packed {
    logic valid;
    logic write;
    logic [27:0] addr;
  } pad_req_t;

  // Registered decode result
  typedef struct packed {
    logic bus_active;
    logic sel_fixed;
    logic sel_can;
    logic sel_prog;
    logic alias_hit;
    logic write;
    logic [13:0] offset;
  } pad_sel_t;

  // Target class of one access
  typedef enum logic [1:0] {
    PAD_TGT_NONE = 2'b00,
    PAD_TGT_FIXED = 2'b01,
    PAD_TGT_CAN = 2'b10,
    PAD_TGT_PROG = 2'b11
  } pad_tgt_t;

endpackage : pad_pkg
